/* File: src/dsc_pkg.sv */
// Package of constants and types for the dual-slope conversion sequencer
package dsc_pkg;
  // Phase select codes {first, second}
  localparam logic [1:0] SEL_AUTOZERO = 2'h1;
  localparam logic [1:0] SEL_INTEGRATE = 2'h2;
  localparam logic [1:0] SEL_RAMP = 2'h3;
  localparam logic [1:0] SEL_INTZERO = 2'h0;
  // Clock and times
  localparam int CLK_HZ = 25000000;
  localparam int INTZERO_FIXED_US = 2000;
  localparam int INTZERO_FIXED_CYC = (CLK_HZ / 1000000) * INTZERO_FIXED_US;
  // Default integrate count: 40 ms, a multiple of the 50 Hz line period
  localparam int INTEGRATE_MS = 40;
  localparam int INTEGRATE_CYC = (CLK_HZ / 1000) * INTEGRATE_MS;
  localparam int COUNT_W = 24;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
  // Ramp cycles until the comparator can show its response to the ramp code
  localparam int RAMP_SETTLE_CYC = 2;

  typedef enum logic [2:0] {
    DSC_IDLE     = 3'b000,
    DSC_AUTOZERO = 3'b001,
    DSC_INTEG    = 3'b010,
    DSC_RAMP     = 3'b011,
    DSC_INTZERO  = 3'b100
  } dsc_state_t;
endpackage

/* File: src/dsc_phase_if.sv */
// Interface carrying phase code and comparator sample between modules
`timescale 1ns/1ps
interface dsc_phase_if;
  logic [1:0] phase_sel;
  logic       comp;
  logic       comp_low;
  modport ctrl (output phase_sel, input comp_low, input comp);
  modport pins (input phase_sel, output comp_low, output comp);
endinterface

/* File: src/dsc_pin_stage.sv */
// Pin stage: registered phase select outputs, comparator passed through unregistered
`timescale 1ns/1ps
module dsc_pin_stage (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Pins
  input  wire logic comp_i,
  output logic      sel_a_o,
  output logic      sel_b_o,
  // Controller side
  dsc_phase_if.pins pif
);
  logic [1:0] sel_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_q <= dsc_pkg::SEL_INTZERO;
    end else begin
      sel_q <= pif.phase_sel;
    end
  end

  assign sel_a_o      = sel_q[1];
  assign sel_b_o      = sel_q[0];
  assign pif.comp     = comp_i;
  assign pif.comp_low = ~comp_i;
endmodule

/* File: src/dsc_sequencer.sv */
// Top: controller that sequences a dual-slope converter front end
// Contract
// R01 - Integration lasts a fixed programmed count of own clock cycles.
// R02 - Front end picks reference polarity itself; no polarity output here.
// R03 - Comparator falling during ramp means conversion complete.
// R04 - Count clock periods from ramp start until completion.
// R05 - Integrator-zero may end once comparator returns high.
// R06 - Comparator stays low through integration for negative input.
// R07 - Near-zero negative input may give no falling edge at all.
// R08 - Polled mode ends ramp on first low comparator sample.
// R09 - Interrupt mode samples at ramp start; low ends ramp at once.
// R10 - Integration count configurable as multiple of line period.
// R11 - Phase codes: autozero 01, integrate 10, ramp 11, intzero 00.
// R12 - Comparator level at end of integration stored as sign, high positive.
// R13 - Comparator ignored during autozero and integrator-zero; code reads it in integrator-zero unless iz_fixed_i is set.
// R14 - Integrator-zero alternatively runs a fixed interval of about 2 ms.
// R15 - Phases run autozero, integrate, ramp, intzero, then repeat.
// R16 - Autozero defaults to integrate count; overrange at maximum ramp count.
`timescale 1ns/1ps
module dsc_sequencer #(
  parameter int COUNT_W = dsc_pkg::COUNT_W,
  parameter int INT_CYCLES = dsc_pkg::INTEGRATE_CYC,
  parameter int IZ_CYCLES = dsc_pkg::INTZERO_FIXED_CYC
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // Control
  input  wire logic               start_i,
  input  wire logic               continuous_i,
  input  wire logic               edge_mode_i,
  input  wire logic               iz_fixed_i,
  input  wire logic               az_separate_i,
  input  wire logic [COUNT_W-1:0] az_count_i,
  input  wire logic [COUNT_W-1:0] int_count_i,
  // Front end pins
  input  wire logic               comp_i,
  output logic                    sel_a_o,
  output logic                    sel_b_o,
  // Result
  output logic                    busy_o,
  output logic                    done_o,
  output logic [COUNT_W-1:0]      deintegrate_count_o,
  output logic                    sign_o,
  output logic                    overrange_o,
  output logic                    irq_armed_o
);
  if (COUNT_W < 8 || COUNT_W > 32) begin : g_bad_width
    $error("COUNT_W out of range");
  end
  if (INT_CYCLES < 1 || IZ_CYCLES <= dsc_pkg::RAMP_SETTLE_CYC) begin : g_bad_cycles
    $error("cycle counts out of range");
  end
  if ((IZ_CYCLES >> COUNT_W) != 0) begin : g_bad_iz
    $error("IZ_CYCLES does not fit the counter");
  end

  localparam logic [COUNT_W-1:0] CNT_MAX = {COUNT_W{1'b1}};
  localparam logic [COUNT_W-1:0] CNT_ONE = {{(COUNT_W-1){1'b0}}, 1'b1};
  localparam logic [COUNT_W-1:0] IZ_LEN = IZ_CYCLES[COUNT_W-1:0];
  localparam logic [COUNT_W-1:0] SETTLE = COUNT_W'(dsc_pkg::RAMP_SETTLE_CYC);

  dsc_phase_if pif ();

  dsc_pin_stage u_pins (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .comp_i  (comp_i),
    .sel_a_o (sel_a_o),
    .sel_b_o (sel_b_o),
    .pif     (pif)
  );

  dsc_pkg::dsc_state_t state_q, state_d;
  logic [COUNT_W-1:0] timer_q, timer_d;
  logic [COUNT_W-1:0] int_len_q;
  logic [COUNT_W-1:0] result_q, result_d;
  logic               sign_q, sign_d;
  logic               ovr_q, ovr_d;
  logic               done_q;
  logic               armed_q, armed_d;
  logic               comp_prev_q;

  // Decodes
  wire logic [COUNT_W-1:0] int_len = (int_count_i == '0) ? CNT_ONE : int_count_i; // R10
  wire logic [COUNT_W-1:0] az_len = az_separate_i ? az_count_i : int_len; // R16
  wire logic timer_done = (timer_q == CNT_ONE);
  wire logic fall_edge = comp_prev_q & ~pif.comp;
  // Comparator trusted once it has responded to the ramp code at the pins
  wire logic ramp_live = (timer_q >= SETTLE); // R03
  wire logic ramp_first = (timer_q == SETTLE); // R09
  wire logic edge_wait = edge_mode_i & ~ramp_first;
  // Ramp ends on low sample (polled) or on edge / low-at-start (armed)
  wire logic ramp_end = ramp_live & (edge_wait ? fall_edge : pif.comp_low); // R03 R08 R09
  wire logic ramp_max = (timer_q == CNT_MAX); // R16
  wire logic iz_end = iz_fixed_i ? timer_done : pif.comp; // R05 R14
  wire logic go = start_i | continuous_i;

  // Phase code drive
  always_comb begin
    case (state_q)
      dsc_pkg::DSC_AUTOZERO: pif.phase_sel = dsc_pkg::SEL_AUTOZERO; // R11
      dsc_pkg::DSC_INTEG:    pif.phase_sel = dsc_pkg::SEL_INTEGRATE; // R11
      dsc_pkg::DSC_RAMP:     pif.phase_sel = dsc_pkg::SEL_RAMP; // R11
      default:               pif.phase_sel = dsc_pkg::SEL_INTZERO; // R11
    endcase
  end

  // Sequencer
  always_comb begin
    state_d  = state_q;
    timer_d  = timer_q;
    result_d = result_q;
    sign_d   = sign_q;
    ovr_d    = ovr_q;
    armed_d  = armed_q;
    case (state_q)
      dsc_pkg::DSC_IDLE: begin
        if (go) begin
          state_d = dsc_pkg::DSC_AUTOZERO; // R15
          timer_d = (az_len == '0) ? CNT_ONE : az_len;
        end
      end
      // Comparator is not looked at here
      dsc_pkg::DSC_AUTOZERO: begin
        timer_d = timer_q - CNT_ONE; // R13
        if (timer_done) begin
          state_d = dsc_pkg::DSC_INTEG; // R15
          timer_d = int_len_q; // R01
        end
      end
      dsc_pkg::DSC_INTEG: begin
        timer_d = timer_q - CNT_ONE; // R01
        if (timer_done) begin
          state_d = dsc_pkg::DSC_RAMP; // R15
          sign_d  = pif.comp; // R12
          armed_d = 1'b0; // R09
          timer_d = '0; // R04
          ovr_d   = 1'b0;
        end
      end
      dsc_pkg::DSC_RAMP: begin
        timer_d = timer_q + CNT_ONE; // R04
        if (ramp_first && edge_mode_i) begin
          armed_d = pif.comp; // R07 R09
        end
        if (ramp_end || ramp_max) begin
          state_d  = dsc_pkg::DSC_INTZERO; // R15
          result_d = timer_q; // R04
          ovr_d    = ramp_max & ~ramp_end; // R16
          armed_d  = 1'b0; // R09
          timer_d  = IZ_LEN; // R14
        end
      end
      dsc_pkg::DSC_INTZERO: begin
        timer_d = timer_q - CNT_ONE;
        if (iz_end) begin
          state_d = go ? dsc_pkg::DSC_AUTOZERO : dsc_pkg::DSC_IDLE; // R15
          timer_d = (az_len == '0) ? CNT_ONE : az_len;
        end
      end
      default: begin
        state_d = dsc_pkg::DSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q     <= dsc_pkg::DSC_IDLE;
      timer_q     <= COUNT_W'(dsc_pkg::COUNT_RESET);
      int_len_q   <= CNT_ONE;
      result_q    <= '0;
      sign_q      <= 1'b0;
      ovr_q       <= 1'b0;
      done_q      <= 1'b0;
      armed_q     <= 1'b0;
      comp_prev_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      timer_q     <= timer_d;
      result_q    <= result_d;
      sign_q      <= sign_d;
      ovr_q       <= ovr_d;
      armed_q     <= armed_d;
      comp_prev_q <= pif.comp;
      done_q      <= (state_q == dsc_pkg::DSC_RAMP) && (state_d == dsc_pkg::DSC_INTZERO);
      if (state_q != dsc_pkg::DSC_AUTOZERO && state_d == dsc_pkg::DSC_AUTOZERO) begin
        int_len_q <= int_len; // R10
      end
    end
  end

  assign busy_o              = (state_q != dsc_pkg::DSC_IDLE);
  assign done_o              = done_q;
  assign deintegrate_count_o = result_q;
  assign sign_o              = sign_q;
  assign overrange_o         = ovr_q;
  assign irq_armed_o         = armed_q;

  // Checks
  sequence s_ramp_low;
    state_q == dsc_pkg::DSC_RAMP && ramp_live && !edge_mode_i && !comp_i;
  endsequence
  sequence s_to_iz;
    state_q == dsc_pkg::DSC_INTZERO;
  endsequence

  a_ramp_poll_end: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R08
    s_ramp_low |=> s_to_iz)
    else $error("ramp did not end on low sample");
  a_phase_order: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R15
    state_q == dsc_pkg::DSC_INTEG && state_d != state_q |-> state_d == dsc_pkg::DSC_RAMP)
    else $error("integrate not followed by ramp");
  a_integ_code: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    state_q == dsc_pkg::DSC_INTEG |=> sel_a_o && !sel_b_o)
    else $error("integrate code wrong");
  a_ramp_code: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
    state_q == dsc_pkg::DSC_RAMP |=> sel_a_o && sel_b_o)
    else $error("ramp code wrong");
  a_sign_store: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
    state_q == dsc_pkg::DSC_INTEG && timer_done |=> sign_o == $past(comp_i))
    else $error("sign not stored");
  a_int_length: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R01
    $rose(state_q == dsc_pkg::DSC_INTEG) |-> timer_q == int_len_q)
    else $error("integrate length wrong");
  a_ramp_count: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R04
    state_q == dsc_pkg::DSC_RAMP && state_d == dsc_pkg::DSC_INTZERO |=>
    deintegrate_count_o == $past(timer_q) && done_o)
    else $error("ramp count not captured");
  a_irq_low_start: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R09
    state_q == dsc_pkg::DSC_RAMP && edge_mode_i && ramp_first && !comp_i |=> s_to_iz)
    else $error("low start did not end ramp");
  a_irq_arm_high: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R09
    state_q == dsc_pkg::DSC_RAMP && edge_mode_i && ramp_first && comp_i && !ramp_max |=>
    irq_armed_o)
    else $error("interrupt not armed on high start");
  a_ramp_settle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R03
    state_q == dsc_pkg::DSC_RAMP && !ramp_live |=> state_q == dsc_pkg::DSC_RAMP)
    else $error("ramp ended before comparator settled");
  a_iz_comp_high: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R05
    state_q == dsc_pkg::DSC_INTZERO && !iz_fixed_i && comp_i |=> !(state_q == dsc_pkg::DSC_INTZERO))
    else $error("intzero did not end on high");
endmodule

/* File: verification/dsc_front_end_model.sv */
// Behavioural model of the converter front end
`timescale 1ns/1ps
module dsc_front_end_model #(
  parameter int VREF = 4
) (
  // Clock and phase select
  input  wire logic               clk_i,
  input  wire logic               sel_a_i,
  input  wire logic               sel_b_i,
  // Analog input as a signed level
  input  wire logic signed [15:0] vin_i,
  // Comparator
  output logic                    comp_o
);
  int   integ_q;
  int   zero_q;
  logic weak_q;
  initial begin
    integ_q = 0;
    zero_q  = 0;
    weak_q  = 1'b0;
    comp_o  = 1'b0;
  end
  always @(posedge clk_i) begin
    case ({sel_a_i, sel_b_i})
      2'h2: begin
        integ_q <= integ_q + vin_i;
        comp_o  <= (integ_q + vin_i) >= 0;
        weak_q  <= (integ_q + vin_i) < 0 && (integ_q + vin_i) >= -4 * VREF;
      end
      2'h3: begin
        // Reference of opposite polarity chosen here
        integ_q <= (integ_q > 0) ? integ_q - VREF : integ_q + VREF;
        comp_o  <= !weak_q && (integ_q > 0 ? integ_q > VREF : integ_q < -VREF);
      end
      2'h1: begin
        integ_q <= 0;
        zero_q  <= 0;
        comp_o  <= ~comp_o;
      end
      default: begin
        integ_q <= 0;
        zero_q  <= zero_q + 1;
        comp_o  <= (zero_q >= 3) ? 1'b1 : ~comp_o;
      end
    endcase
  end
endmodule

/* File: verification/dsc_sequencer_bench.sv */
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module dsc_sequencer_bench;
  logic              clk_i, rst_n_i, start_i, edge_mode_i, iz_fixed_i, az_separate_i;
  logic              comp_i, sel_a_o, sel_b_o, busy_o, done_o, sign_o, overrange_o;
  logic              continuous_i, irq_armed_o, armed_seen;
  logic [7:0]        cnt_o, az_cnt, int_cnt;
  logic [7:0]        lfsr_q;
  logic signed [15:0] vin;
  logic [9:0]        exp_q[$];
  logic [9:0]        e;
  logic [1:0]        sel_q;
  int                mismatches, checked, run_len, d;

  dsc_sequencer #(.COUNT_W(8), .INT_CYCLES(16), .IZ_CYCLES(20)) u_dut (
    .clk_i, .rst_n_i, .start_i, .continuous_i, .edge_mode_i, .iz_fixed_i,
    .az_separate_i, .az_count_i(az_cnt), .int_count_i(int_cnt), .comp_i, .sel_a_o,
    .sel_b_o, .busy_o, .done_o, .deintegrate_count_o(cnt_o), .sign_o, .overrange_o,
    .irq_armed_o);
  dsc_front_end_model #(.VREF(4)) u_model (
    .clk_i, .sel_a_i(sel_a_o), .sel_b_i(sel_b_o), .vin_i(vin), .comp_o(comp_i));

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want) begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, got, want);
    end
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic conv(input int v, input logic em, input logic izf, input logic azs,
                      input logic cont);
    int n;
    int k;
    vin = v[15:0];
    edge_mode_i = em;
    iz_fixed_i = izf;
    az_separate_i = azs;
    az_cnt = {5'h0, lfsr_q[2:0]} + 8'h02;
    k = (v < 0 ? -v : v) * 16 / 4;
    if (v < 0 && v * 16 >= -16) k = 0;
    repeat (cont ? 2 : 1) exp_q.push_back({k > 255, v > 0, k > 255 ? 8'hff : k[7:0]});
    continuous_i = cont;
    start_i = 1'b1;
    @(posedge clk_i);
    #1 start_i = 1'b0;
    n = 0;
    if (cont) begin
      while (done_o !== 1'b1 && n < 3000) begin
        @(posedge clk_i);
        #1 n++;
      end
      while ({sel_a_o, sel_b_o} !== dsc_pkg::SEL_AUTOZERO && n < 3000) begin
        @(posedge clk_i);
        #1 n++;
      end
      continuous_i = 1'b0;
    end
    while (busy_o !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n == 3000) mismatches++;
  endtask

  // Result and phase monitor
  always @(posedge clk_i) begin
    if (irq_armed_o === 1'b1) armed_seen = 1'b1;
    if (done_o === 1'b1) begin
      e = exp_q.pop_front();
      d = int'(cnt_o) - int'(e[7:0]);
      chk({6'h0, overrange_o, sign_o}, {6'h0, e[9:8]});
      if (!e[9]) chk((d >= -2 && d <= 2) ? e[7:0] : cnt_o, e[7:0]);
      chk({7'h0, armed_seen}, {7'h0, edge_mode_i && e[7:0] != 8'h00});
      armed_seen = 1'b0;
    end
    if ({sel_a_o, sel_b_o} !== sel_q) begin
      chk({6'h0, sel_a_o, sel_b_o}, {6'h0, sel_q + 2'h1});
      if (sel_q == dsc_pkg::SEL_INTEGRATE) chk(run_len[7:0], int_cnt);
      if (sel_q == dsc_pkg::SEL_AUTOZERO) chk(run_len[7:0], az_separate_i ? az_cnt : int_cnt);
      run_len = 1;
    end else begin
      run_len++;
    end
    sel_q = {sel_a_o, sel_b_o};
  end

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    #(40 * 40000);
    mismatches++;
    report_and_stop();
  end

  initial begin
    rst_n_i = 1'b0;
    start_i = 1'b0;
    edge_mode_i = 1'b0;
    iz_fixed_i = 1'b0;
    az_separate_i = 1'b0;
    continuous_i = 1'b0;
    armed_seen = 1'b0;
    int_cnt = 8'h10;
    az_cnt = 8'h05;
    vin = 16'sh0001;
    lfsr_q = 8'h12;
    mismatches = 0;
    checked = 0;
    run_len = 0;
    sel_q = 2'h0;
    repeat (6) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      conv(i[0] ? -int'(lfsr_q % 40) - 3 : int'(lfsr_q % 40) + 1, i[1], i[2], i[2],
           1'b0);
    end
    conv(-1, 1'b0, 1'b0, 1'b0, 1'b0);
    conv(-1, 1'b1, 1'b0, 1'b0, 1'b0);
    conv(100, 1'b1, 1'b1, 1'b1, 1'b0);
    conv(9, 1'b0, 1'b0, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule
